// ==== rtl/rco_pkg.sv ====
// Package with the register map and field layout of the reference clock output unit
package rco_pkg;
	// Register byte offset on the APB bus
	localparam logic [11:0] RCO_CTRL_OFS     = 12'h000;
	// Field positions inside the 16-bit control register
	localparam int          RCO_EN_BIT       = 15;
	localparam int          RCO_KEEP_BIT     = 13;
	localparam int          RCO_SEL_BIT      = 12;
	localparam int          RCO_DIV_MSB      = 11;
	localparam int          RCO_DIV_LSB      = 8;
	localparam int          RCO_DIV_W        = 4;
	// Width of the power-of-two prescaler, enough for the largest ratio
	localparam int          RCO_CNT_W        = 15;
	// Reset value of every implemented control bit
	localparam logic        RCO_BIT_RST      = 1'b0;
	localparam logic [3:0]  RCO_DIV_RST      = 4'h0;
	// Read data filler for unimplemented bits
	localparam logic [31:0] RCO_RD_ZERO      = 32'h0000_0000;
endpackage : rco_pkg

// ==== rtl/rco_ref_clock_out.sv ====
// Reference clock output divider with its APB control register
// Operation
// - Output enable bit 15 drives the divided reference clock onto the pin.
// - Four-bit divider field in bits 11:8 selects sixteen division ratios.
// - Codes 0001 to 1111 divide the base clock by two to the code.
// - Base select bit 12 set picks the primary oscillator, cleared the system clock.
// - Sleep-keep bit 13 set keeps output running in Sleep, cleared stops it.
// - Output runs in Sleep only with keep, base select and primary oscillator mode.
// - Base select cleared powers the primary oscillator down on Sleep entry.
// - Base select cleared makes the output follow system clock switches.
// - Output works in every oscillator configuration.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module rco_ref_clock_out
	import rco_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_osc_pin_in,
	input  wire logic        i_sys_clk_src,
	input  wire logic        i_sleep,
	input  wire logic        i_primary_mode,
	output logic             o_ref_clock_pin,
	output logic             o_ref_clock_pin_oe,
	output logic             o_osc_pin_out_pwrdn
);

	// Control register fields
	logic                 ref_out_enable_q;
	logic                 ref_sleep_keep_q;
	logic                 ref_base_select_q;
	logic [RCO_DIV_W-1:0] ref_divider_select_q;

	// Bus handshake state
	logic                 pready_q;
	logic                 pslverr_q;
	logic [31:0]          prdata_q;
	logic                 hit;
	logic                 wr_take;
	logic [31:0]          ctrl_rd;

	// Clock generation state
	logic                 base_lvl;
	logic                 base_prev_q;
	logic                 base_rise;
	logic                 sleep_hold;
	logic                 run;
	logic [RCO_CNT_W-1:0] cnt_q;
	logic [RCO_CNT_W-1:0] cnt_d;
	logic [RCO_DIV_W-1:0] div_m1;
	logic                 tap;
	logic                 out_q;
	logic                 oe_q;
	logic                 pwrdn_q;

	// Address decode and the edge at which a write lands
	assign hit     = (i_paddr == RCO_CTRL_OFS);
	assign wr_take = i_psel & i_penable & pready_q & i_pwrite & hit;

	// Read image; unimplemented bits stay zero
	always_comb begin
		ctrl_rd                          = RCO_RD_ZERO;
		ctrl_rd[RCO_EN_BIT]              = ref_out_enable_q;
		ctrl_rd[RCO_KEEP_BIT]            = ref_sleep_keep_q;
		ctrl_rd[RCO_SEL_BIT]             = ref_base_select_q;
		ctrl_rd[RCO_DIV_MSB:RCO_DIV_LSB] = ref_divider_select_q;
	end

	// Zero-wait answer: ready rises during the access phase, drops after it
	// Error and data are decided at setup so the access cycle needs no decode
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= RCO_RD_ZERO;
		end else if (i_psel && !i_penable) begin
			pready_q  <= 1'b1;
			pslverr_q <= !hit;
			prdata_q  <= (hit && !i_pwrite) ? ctrl_rd : RCO_RD_ZERO;
		end else begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= RCO_RD_ZERO;
		end
	end

	// Control register; only byte lane 1 holds implemented bits
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ref_out_enable_q     <= RCO_BIT_RST;
			ref_sleep_keep_q     <= RCO_BIT_RST;
			ref_base_select_q    <= RCO_BIT_RST;
			ref_divider_select_q <= RCO_DIV_RST;
		end else if (wr_take && i_pstrb[1]) begin
			ref_out_enable_q     <= i_pwdata[RCO_EN_BIT];
			ref_sleep_keep_q     <= i_pwdata[RCO_KEEP_BIT];
			ref_base_select_q    <= i_pwdata[RCO_SEL_BIT];
			ref_divider_select_q <= i_pwdata[RCO_DIV_MSB:RCO_DIV_LSB];
		end
	end

	// Base clock choice; with the system clock chosen, a clock switch shows at once
	assign base_lvl = ref_base_select_q ? i_osc_pin_in : i_sys_clk_src;

	// Sleep gating: only the kept primary oscillator survives Sleep
	assign sleep_hold = ref_sleep_keep_q & ref_base_select_q & i_primary_mode;
	// Awake, no oscillator mode is required
	assign run        = ref_out_enable_q & (!i_sleep | sleep_hold);

	// Edge of the base clock, sampled at the system rate
	// Limitation: a base clock at or above half of i_clk loses edges here
	assign base_rise = base_lvl & !base_prev_q;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			base_prev_q <= 1'b0;
		end else begin
			base_prev_q <= base_lvl;
		end
	end

	// Prescaler counts base edges; cleared while stopped so restarts are clean
	always_comb begin
		cnt_d = cnt_q;
		if (!run) begin
			cnt_d = '0;
		end else if (base_rise) begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Counter bit n-1 toggles every 2^(n-1) edges, a period of 2^n
	// Code zero has no counter bit; div_m1 wraps there and is not used
	assign div_m1 = ref_divider_select_q - 4'h1;
	assign tap    = (ref_divider_select_q == RCO_DIV_RST) ? base_lvl : cnt_q[div_m1];

	// Pin drive; the level is low whenever the output is stopped
	// Enable follows bit 15 alone, so the pin stays driven in Sleep but floats once the output is disabled
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			out_q <= 1'b0;
			oe_q  <= 1'b0;
		end else begin
			out_q <= run & tap;
			oe_q  <= ref_out_enable_q;
		end
	end

	// Primary oscillator power-down in Sleep unless the reference keeps it
	// Keep without base select does not hold the oscillator up
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			pwrdn_q <= 1'b0;
		end else begin
			pwrdn_q <= i_sleep & !(ref_sleep_keep_q & ref_base_select_q);
		end
	end

	assign o_prdata            = prdata_q;
	assign o_pready            = pready_q;
	assign o_pslverr           = pslverr_q;
	assign o_ref_clock_pin     = out_q;
	assign o_ref_clock_pin_oe  = oe_q;
	assign o_osc_pin_out_pwrdn = pwrdn_q;

	// Checks on the divider and control path
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	AST_PIN_DRIVE: assert property (ref_out_enable_q |=> o_ref_clock_pin_oe)
		else $error("pin not driven while output enabled");

	AST_PIN_IDLE: assert property (!ref_out_enable_q |=> !o_ref_clock_pin)
		else $error("pin toggles while output disabled");

	AST_DIV_TAP: assert property (
		run && ref_divider_select_q != 4'h0 |=> o_ref_clock_pin == $past(cnt_q[div_m1]))
		else $error("pin does not follow selected prescaler bit");

	AST_CNT_STEP: assert property (
		run && base_rise |=> cnt_q == $past(cnt_q) + 15'h0001)
		else $error("prescaler missed a base clock edge");

	AST_BASE_OSC: assert property (ref_base_select_q |-> base_lvl == i_osc_pin_in)
		else $error("oscillator not used as base");

	AST_SLEEP_STOP: assert property (
		i_sleep && !ref_sleep_keep_q |=> !o_ref_clock_pin && cnt_q == 15'h0000)
		else $error("output runs in Sleep without keep");

	AST_SLEEP_KEEP: assert property (
		i_sleep && ref_out_enable_q && ref_sleep_keep_q && ref_base_select_q
		&& i_primary_mode |-> run)
		else $error("kept output stopped in Sleep");

	AST_OSC_OFF: assert property (i_sleep && !ref_base_select_q |=> o_osc_pin_out_pwrdn)
		else $error("oscillator not powered down in Sleep");

	AST_SYS_FOLLOW: assert property (!ref_base_select_q |-> base_lvl == i_sys_clk_src)
		else $error("base does not follow system clock");

	AST_ANY_MODE: assert property (ref_out_enable_q && !i_sleep |-> run)
		else $error("output stopped while awake");

	AST_PASS: assert property (
		run && ref_divider_select_q == 4'h0 |=> o_ref_clock_pin == $past(base_lvl))
		else $error("code zero does not pass base clock");

	AST_RESV_ZERO: assert property (
		o_pready |-> o_prdata[14] == 1'b0 && o_prdata[7:0] == 8'h00
		&& o_prdata[31:16] == 16'h0000)
		else $error("unimplemented bits read non-zero");

	AST_RST_VAL: assert property ($past(i_srst) |-> ctrl_rd == RCO_RD_ZERO)
		else $error("control bits not zero after reset");

	// Each implemented field takes its bit from the landing write
	AST_EN_LAND: assert property (
		wr_take && i_pstrb[1] |=> ref_out_enable_q == $past(i_pwdata[RCO_EN_BIT]))
		else $error("enable bit not taken from write");

	AST_DIV_LAND: assert property (
		wr_take && i_pstrb[1]
		|=> ref_divider_select_q == $past(i_pwdata[RCO_DIV_MSB:RCO_DIV_LSB]))
		else $error("divider field not taken from write");

	AST_SEL_LAND: assert property (
		wr_take && i_pstrb[1] |=> ref_base_select_q == $past(i_pwdata[RCO_SEL_BIT]))
		else $error("base select bit not taken from write");

	AST_KEEP_LAND: assert property (
		wr_take && i_pstrb[1] |=> ref_sleep_keep_q == $past(i_pwdata[RCO_KEEP_BIT]))
		else $error("sleep-keep bit not taken from write");

	// Without a landing write the register image must not move
	AST_HOLD_FIELDS: assert property (
		!(wr_take && i_pstrb[1]) |=> $stable(ctrl_rd))
		else $error("control bits changed without a write");

	// A read returns the image of the setup cycle, a refused access reads zero
	AST_RD_IMAGE: assert property (
		o_pready && !o_pslverr && !$past(i_pwrite) |-> o_prdata == $past(ctrl_rd))
		else $error("read data differs from the register image");

	AST_ERR_ZERO: assert property (o_pslverr |-> o_prdata == RCO_RD_ZERO)
		else $error("refused access returned data");

	// Output enable drops with the enable bit
	AST_OE_OFF: assert property (!ref_out_enable_q |=> !o_ref_clock_pin_oe)
		else $error("pin still driven after disable");

	// Prescaler holds between base edges and is cleared while stopped
	AST_CNT_HOLD: assert property (
		run && !base_rise |=> cnt_q == $past(cnt_q))
		else $error("prescaler moved without a base clock edge");

	AST_STOP_CLEAR: assert property (
		!run |=> cnt_q == 15'h0000 && !o_ref_clock_pin)
		else $error("prescaler or pin active while stopped");

	// Sleep stops the pin outside primary modes or with the system clock as base
	AST_NO_PRIMARY: assert property (
		i_sleep && !i_primary_mode |=> !o_ref_clock_pin)
		else $error("output runs in Sleep outside primary modes");

	AST_SEL_SLEEP: assert property (
		i_sleep && !ref_base_select_q |=> !o_ref_clock_pin)
		else $error("output runs in Sleep from the system clock");

	// The oscillator stays powered while awake or while kept for the reference
	AST_OSC_AWAKE: assert property (!i_sleep |=> !o_osc_pin_out_pwrdn)
		else $error("oscillator powered down while awake");

	AST_OSC_KEPT: assert property (
		i_sleep && ref_sleep_keep_q && ref_base_select_q |=> !o_osc_pin_out_pwrdn)
		else $error("kept oscillator powered down in Sleep");

	// Main scenarios worth seeing in a run
	COV_WRITE: cover property (wr_take && i_pstrb[1] && i_pwdata[RCO_EN_BIT]);
	COV_MAX_DIV: cover property (run && ref_divider_select_q == 4'hF && $rose(o_ref_clock_pin));
	COV_SLEEP_RUN: cover property (i_sleep && run && $rose(o_ref_clock_pin));
	COV_BAD_ADDR: cover property (o_pready && o_pslverr);
	COV_OSC_PWRDN: cover property ($rose(o_osc_pin_out_pwrdn));

endmodule : rco_ref_clock_out

// ==== verif/rco_ext_device.sv ====
// External device model that samples the reference pin on the system clock and measures its period
`timescale 1ns/100ps
module rco_ext_device (
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire logic        i_pin,
	output logic      [31:0] o_period,
	output logic      [31:0] o_rises
);
	logic        pin_q;
	logic [31:0] cnt_q;
	// Counts system cycles between rising pin edges, as a counting input of a real device would
	always_ff @(posedge i_clk) begin
		pin_q <= i_pin;
		cnt_q <= (i_pin && !pin_q) ? 32'h0000_0001 : cnt_q + 32'h0000_0001;
		if (i_srst) begin
			o_rises <= 32'h0000_0000;
		end else if (i_pin && !pin_q) begin
			o_period <= cnt_q;
			o_rises  <= o_rises + 32'h0000_0001;
		end
	end
endmodule : rco_ext_device

// ==== verif/tb_rco_ref_clock_out.sv ====
// Self-checking bench for the reference clock output divider
`timescale 1ns/100ps
module tb_rco_ref_clock_out;
	import rco_pkg::*;
	logic        clk, srst, psel, penable, pwrite, osc, sys, sleep, prim;
	logic        pready, pslverr, pin, oe, pwrdn, err;
	logic [11:0] paddr;
	logic [3:0]  pstrb;
	logic [31:0] pwdata, prdata, rd, period, rises;
	int          err_count, n_compared, sd;
	int          t = 0;
	int          codes[5] = '{0, 1, 2, 3, 8};

	rco_ref_clock_out i_rco_ref_clock_out (.i_clk(clk), .i_srst(srst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_osc_pin_in(osc), .i_sys_clk_src(sys), .i_sleep(sleep), .i_primary_mode(prim),
		.o_ref_clock_pin(pin), .o_ref_clock_pin_oe(oe), .o_osc_pin_out_pwrdn(pwrdn));
	rco_ext_device i_rco_ext_device (.i_clk(clk), .i_srst(srst), .i_pin(pin),
		.o_period(period), .o_rises(rises));

	always #5 clk = ~clk;
	// Base clocks: system source period 2*2^sd cycles, oscillator period 6 cycles
	always @(posedge clk) begin
		t   <= t + 1;
		sys <= t[sd];
		osc <= (t % 6) < 3;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Settles for three rising pin edges, then checks the last period
	task automatic meas(input logic [31:0] exp);
		logic [31:0] r0;
		r0 = rises;
		wait (rises == r0 + 32'h0000_0003);
		chk(period, exp);
	endtask : meas

	// Pin must stay low with no edge over 200 cycles, longer than any period in force where it is used
	task automatic stopped();
		logic [31:0] r0;
		repeat (4) @(posedge clk);
		r0 = rises;
		repeat (200) @(posedge clk);
		chk(rises, r0);
		chk(pin, 1'b0);
	endtask : stopped

	task automatic give_verdict();
		$display("compared=%0d mismatches=%0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict

	// Watchdog, far beyond the longest expected run
	initial begin
		repeat (30000) @(posedge clk);
		err_count++;
		give_verdict();
	end

	initial begin
		{clk, psel, penable, pwrite, sleep, prim, sys, osc} = '0;
		{paddr, pwdata, err_count, n_compared} = '0;
		srst = 1'b1;
		pstrb = 4'hF;
		sd = 1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		apb(1'b0, RCO_CTRL_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b1, RCO_CTRL_OFS, 32'hFFFF_FFFF);
		apb(1'b0, RCO_CTRL_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_BF00);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(err, 1'b1);
		// Divider ratios from the system clock source
		foreach (codes[i]) begin
			apb(1'b1, RCO_CTRL_OFS, 32'h0000_8000 | (32'(codes[i]) << 8));
			meas(32'(4 << codes[i]));
			chk(oe, 1'b1);
		end
		apb(1'b1, RCO_CTRL_OFS, 32'h0000_9200);
		meas(32'h0000_0018);
		apb(1'b1, RCO_CTRL_OFS, 32'h0000_B200);
		sleep <= 1'b1;
		prim  <= 1'b1;
		meas(32'h0000_0018);
		chk(pwrdn, 1'b0);
		apb(1'b1, RCO_CTRL_OFS, 32'h0000_A200);
		stopped();
		chk(pwrdn, 1'b1);
		apb(1'b1, RCO_CTRL_OFS, 32'h0000_9200);
		stopped();
		apb(1'b1, RCO_CTRL_OFS, 32'h0000_B200);
		prim <= 1'b0;
		stopped();
		sleep <= 1'b0;
		apb(1'b1, RCO_CTRL_OFS, 32'h0000_8100);
		meas(32'h0000_0008);
		sd <= 2;
		meas(32'h0000_0010);
		apb(1'b1, RCO_CTRL_OFS, 32'h0000_0000);
		stopped();
		chk(oe, 1'b0);
		// Reset in mid-run with every field set must clear them all
		apb(1'b1, RCO_CTRL_OFS, 32'h0000_BF00);
		repeat (4) @(posedge clk);
		chk(oe, 1'b1);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		apb(1'b0, RCO_CTRL_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk(oe, 1'b0);
		chk(pin, 1'b0);
		give_verdict();
	end
endmodule : tb_rco_ref_clock_out
